/* logic/rlsb_pkg.sv */
// Package with addresses, bit positions, timing constants and carrier types of the latched-status bank.
`default_nettype none
package rlsb_pkg;

    // Host register addresses.
    localparam logic [7:0] RLSB_ADDR_LS4      = 8'h93;
    localparam logic [7:0] RLSB_ADDR_HDLC     = 8'h94;
    localparam logic [7:0] RLSB_ADDR_LS7      = 8'h96;
    localparam logic [7:0] RLSB_ADDR_SIG1     = 8'h98;
    localparam logic [7:0] RLSB_ADDR_SIG2     = 8'h99;
    localparam logic [7:0] RLSB_ADDR_SIG3     = 8'h9a;
    localparam logic [7:0] RLSB_ADDR_SIG4     = 8'h9b;
    localparam logic [7:0] RLSB_ADDR_SPARE_HI = 8'h9c;

    // Values after reset.
    localparam logic [7:0]  RLSB_RST_BYTE = 8'h00;
    localparam logic [31:0] RLSB_RST_SIG  = 32'h0000_0000;

    // Field positions in the fourth latched-status register.
    localparam int RLSB_LS4_MF  = 0;
    localparam int RLSB_LS4_SUM = 3;

    // Field positions in the HDLC latched-status register.
    localparam int RLSB_HD_NE   = 0;
    localparam int RLSB_HD_HWM  = 1;
    localparam int RLSB_HD_PS   = 2;
    localparam int RLSB_HD_PE   = 3;
    localparam int RLSB_HD_OBT  = 4;
    localparam int RLSB_HD_OVR  = 5;

    // Field positions in the seventh latched-status register, T1 and E1 views.
    localparam int RLSB_T1_BD   = 0;
    localparam int RLSB_T1_BC   = 1;
    localparam int RLSB_T1_DLF  = 2;
    localparam int RLSB_T1_C96  = 3;
    localparam int RLSB_T1_AIS  = 4;
    localparam int RLSB_T1_RAI  = 5;
    localparam int RLSB_E1_SAX  = 0;
    localparam int RLSB_E1_SA6  = 1;

    // Channel counts per mode.
    localparam int RLSB_T1_CHANNELS = 24;
    localparam int RLSB_E1_CHANNELS = 32;

    // Free-running E1 multiframe period when CAS is off.
    localparam int RLSB_CLK_MHZ        = 250;
    localparam int RLSB_MF_E1_PERIOD_US = 2000;
    localparam int RLSB_MF_E1_PERIOD_CYC = RLSB_MF_E1_PERIOD_US * RLSB_CLK_MHZ;

    // Host access request.
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rlsb_host_req_t;

    // One-cycle event pulses from the HDLC receiver.
    typedef struct packed {
        logic overrun;
        logic packet_end;
        logic packet_start;
    } rlsb_hdlc_pulse_t;

    // One-cycle event pulses from the T1 alarm and data link detectors.
    typedef struct packed {
        logic remote_alarm_ci_detect;
        logic ais_ci_detect;
        logic carrier96_alignment_event;
        logic data_link_full_event;
    } rlsb_t1_pulse_t;

endpackage
`default_nettype wire

/* logic/rlsb_status_bank.sv */
// Receive latched-status bank: event latches, clear-on-read host port and interrupt line.
//
// Summary of operation
// - T1: multiframe flag sets on each superframe boundary, 1.5 ms D4, 3 ms ESF.
// - E1: multiframe flag sets every 2.0 ms, CAS boundary or free period.
// - Overrun flag sets when HDLC receiver abandons a packet on full FIFO.
// - Opening-byte flag sets when the FIFO head byte starts a message.
// - Packet-end flag sets on good end or fault; clears on read.
// - Packet-start flag sets on detected opening byte; clears on read.
// - Watermark flag sets on rising edge of fill above programmed watermark.
// - Not-empty flag sets when FIFO goes from empty to holding data.
// - RAI-CI flag sets per detection, ESF only, while remote alarm present.
// - AIS-CI flag sets per detection while AIS present; host clears it.
// - 96-frame carrier flag sets on valid alignment in Fs-bit stream.
// - Data link full flag sets when the 8-bit link byte fills.
// - Code detect flag on filtered valid code; clear flag when it disappears.
// - E1: Sa6 codeword flag sets when valid codeword is seen.
// - E1: Sa-change flag sets when any selected Sa bit changes.
// - Per-channel signaling change bits latch until read; 24 or 32 channels.
// - Summary flag only for enabled channels; interrupt only when mask bit set.
// - E1 CAS: channel 1 LSB is alignment, channel 17 LSB reserved/alarm.
// - Writing the first spare-code register restarts detector integration.
// - Spare-code bit 7 is the first pattern bit; unused low bits ignored.
// - Every HDLC flag latches and may interrupt when unmasked.
// - Second spare-code register is ignored for lengths of seven or less.
// - Mask bit 0 blocks a flag from the interrupt, 1 lets it through.
`timescale 1ns/10ps
`default_nettype none
module rlsb_status_bank
    import rlsb_pkg::*;
#(
    parameter int unsigned MF_E1_PERIOD_CYC = RLSB_MF_E1_PERIOD_CYC
) (
    input  wire logic             ref_clk_i,
    input  wire logic             resetn_i,
    input  wire rlsb_host_req_t   host_req_i,
    output logic [7:0]            rd_data_o,
    input  wire logic             e1_mode_i,
    input  wire logic             esf_mode_i,
    input  wire logic             cas_enable_i,
    input  wire logic             mf_boundary_i,
    input  wire rlsb_hdlc_pulse_t hdlc_pulse_i,
    input  wire logic             opening_byte_at_head_i,
    input  wire logic [6:0]       fifo_level_i,
    input  wire logic [6:0]       rx_fifo_control_i,
    input  wire rlsb_t1_pulse_t   t1_pulse_i,
    input  wire logic             remote_alarm_condition_i,
    input  wire logic             ais_condition_i,
    input  wire logic             boc_valid_i,
    input  wire logic             spare_bit6_codeword_i,
    input  wire logic [4:0]       spare_bits_i,
    input  wire logic             spare_bits_valid_i,
    input  wire logic [4:0]       spare_bit_select_mask_i,
    input  wire logic [31:0]      signaling_change_i,
    input  wire logic [31:0]      signaling_change_enable_i,
    input  wire logic [7:0]       rx_interrupt_mask_four_i,
    input  wire logic [7:0]       hdlc_mask_i,
    input  wire logic [7:0]       ls7_mask_i,
    input  wire logic [3:0]       spare_code_length_i,
    input  wire logic [7:0]       spare_code_pattern_low_i,
    output logic [15:0]           spare_code_pattern_o,
    output logic [15:0]           spare_code_care_o,
    output logic                  spare_code_restart_o,
    output logic                  interrupt_n_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Host decode.

    logic rd_ls4;
    logic rd_hdlc;
    logic rd_ls7;
    logic [3:0] rd_sig;
    logic wr_spare;

    // Reads clear the addressed register, except the spare-code register; the seventh register clears the view of the mode.
    assign rd_ls4   = host_req_i.rd && (host_req_i.addr == RLSB_ADDR_LS4);
    assign rd_hdlc  = host_req_i.rd && (host_req_i.addr == RLSB_ADDR_HDLC);
    assign rd_ls7   = host_req_i.rd && (host_req_i.addr == RLSB_ADDR_LS7);
    assign rd_sig[0] = host_req_i.rd && (host_req_i.addr == RLSB_ADDR_SIG1);
    assign rd_sig[1] = host_req_i.rd && (host_req_i.addr == RLSB_ADDR_SIG2);
    assign rd_sig[2] = host_req_i.rd && (host_req_i.addr == RLSB_ADDR_SIG3);
    assign rd_sig[3] = host_req_i.rd && (host_req_i.addr == RLSB_ADDR_SIG4);
    assign wr_spare = host_req_i.wr && (host_req_i.addr == RLSB_ADDR_SPARE_HI);

    ////////////////////////////////////////////////////////////////////////////////
    // E1 free-running multiframe timer, used when CAS is off.

    logic [31:0] mf_cnt_q;
    logic [31:0] mf_cnt_d;
    logic        mf_tick;

    // The timer only runs in E1 without CAS so it cannot add ticks in other modes.
    always_comb begin
        mf_tick  = 1'b0;
        mf_cnt_d = mf_cnt_q;
        if (e1_mode_i && !cas_enable_i) begin
            if (mf_cnt_q >= 32'(MF_E1_PERIOD_CYC - 1)) begin
                mf_cnt_d = 32'h0000_0000;
                mf_tick  = 1'b1;
            end else begin
                mf_cnt_d = mf_cnt_q + 32'h0000_0001;
            end
        end else begin
            mf_cnt_d = 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            mf_cnt_q <= 32'h0000_0000;
        end else begin
            mf_cnt_q <= mf_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Condition edge detectors.

    logic       above_watermark_condition;
    logic       fifo_has_data_condition;
    logic       above_wm_q;
    logic       has_data_q;
    logic       head_q;
    logic       boc_q;
    logic [4:0] sa_prev_q;
    logic       above_wm_d;
    logic       has_data_d;
    logic       head_d;
    logic       boc_d;
    logic [4:0] sa_prev_d;

    assign above_watermark_condition = fifo_level_i > rx_fifo_control_i;
    assign fifo_has_data_condition   = fifo_level_i != 7'h00;

    // Previous levels are kept so that only transitions raise flags.
    always_comb begin
        above_wm_d = above_watermark_condition;
        has_data_d = fifo_has_data_condition;
        head_d     = opening_byte_at_head_i;
        boc_d      = boc_valid_i;
        sa_prev_d  = spare_bits_valid_i ? spare_bits_i : sa_prev_q;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            above_wm_q <= 1'b0;
            has_data_q <= 1'b0;
            head_q     <= 1'b0;
            boc_q      <= 1'b0;
            sa_prev_q  <= 5'h00;
        end else begin
            above_wm_q <= above_wm_d;
            has_data_q <= has_data_d;
            head_q     <= head_d;
            boc_q      <= boc_d;
            sa_prev_q  <= sa_prev_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Event set vectors.

    logic [7:0]  set_ls4;
    logic [7:0]  set_hdlc;
    logic [7:0]  set_t1;
    logic [7:0]  set_e1;
    logic [31:0] sig_change_live;

    // T1 ignores channels 25 to 32; channel 1 and 17 LSBs carry CAS extras in E1.
    assign sig_change_live = e1_mode_i ? signaling_change_i
                                       : {8'h00, signaling_change_i[23:0]};

    always_comb begin
        set_ls4  = 8'h00;
        set_hdlc = 8'h00;
        set_t1   = 8'h00;
        set_e1   = 8'h00;
        set_ls4[RLSB_LS4_MF]   = (e1_mode_i && !cas_enable_i) ? mf_tick
                                                              : mf_boundary_i;
        set_ls4[RLSB_LS4_SUM]  = |(sig_change_live & signaling_change_enable_i);
        set_hdlc[RLSB_HD_OVR]  = hdlc_pulse_i.overrun;
        set_hdlc[RLSB_HD_OBT]  = opening_byte_at_head_i && !head_q;
        set_hdlc[RLSB_HD_PE]   = hdlc_pulse_i.packet_end;
        set_hdlc[RLSB_HD_PS]   = hdlc_pulse_i.packet_start;
        set_hdlc[RLSB_HD_HWM]  = above_watermark_condition && !above_wm_q;
        set_hdlc[RLSB_HD_NE]   = fifo_has_data_condition && !has_data_q;
        if (!e1_mode_i) begin
            set_t1[RLSB_T1_RAI] = t1_pulse_i.remote_alarm_ci_detect && esf_mode_i
                                  && remote_alarm_condition_i;
            set_t1[RLSB_T1_AIS] = t1_pulse_i.ais_ci_detect && ais_condition_i;
            set_t1[RLSB_T1_C96] = t1_pulse_i.carrier96_alignment_event;
            set_t1[RLSB_T1_DLF] = t1_pulse_i.data_link_full_event;
            set_t1[RLSB_T1_BD]  = boc_valid_i && !boc_q;
            set_t1[RLSB_T1_BC]  = !boc_valid_i && boc_q;
        end else begin
            set_e1[RLSB_E1_SA6] = spare_bit6_codeword_i;
            set_e1[RLSB_E1_SAX] = spare_bits_valid_i
                && (|((spare_bits_i ^ sa_prev_q) & spare_bit_select_mask_i));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Latched flags: a set in the cycle of the read survives the clear.

    logic [7:0]  ls4_q;
    logic [7:0]  hdlc_q;
    logic [7:0]  t1_q;
    logic [7:0]  e1_q;
    logic [7:0]  ls4_d;
    logic [7:0]  hdlc_d;
    logic [7:0]  t1_d;
    logic [7:0]  e1_d;

    always_comb begin
        ls4_d  = (ls4_q & ~{8{rd_ls4}}) | set_ls4;
        hdlc_d = (hdlc_q & ~{8{rd_hdlc}}) | set_hdlc;
        t1_d   = (t1_q & ~{8{rd_ls7 && !e1_mode_i}}) | set_t1;
        e1_d   = (e1_q & ~{8{rd_ls7 && e1_mode_i}}) | set_e1;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            ls4_q  <= RLSB_RST_BYTE;
            hdlc_q <= RLSB_RST_BYTE;
            t1_q   <= RLSB_RST_BYTE;
            e1_q   <= RLSB_RST_BYTE;
        end else begin
            ls4_q  <= ls4_d;
            hdlc_q <= hdlc_d;
            t1_q   <= t1_d;
            e1_q   <= e1_d;
        end
    end

    // Per-channel signaling latches, one per channel, each cleared by a read of its byte.
    logic [31:0] sig_q;
    logic [31:0] sig_d;

    genvar ch;
    generate
        for (ch = 0; ch < RLSB_E1_CHANNELS; ch++) begin : g_sig
            always_comb begin
                sig_d[ch] = (sig_q[ch] && !rd_sig[ch / 8]) || sig_change_live[ch];
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            sig_q <= RLSB_RST_SIG;
        end else begin
            sig_q <= sig_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Spare-code definition register and the pattern seen by the detector.

    logic [7:0]  spare_hi_q;
    logic [7:0]  spare_hi_d;
    logic        restart_q;
    logic        restart_d;
    logic [15:0] pat_q;
    logic [15:0] care_q;
    logic [15:0] pat_d;
    logic [15:0] care_d;

    // Care bits grow from bit 15 downward; a zero length is treated as one bit.
    always_comb begin
        spare_hi_d = wr_spare ? host_req_i.wdata : spare_hi_q;
        restart_d  = wr_spare;
        care_d     = 16'h0000;
        for (int b = 0; b < 16; b++) begin
            if ((b < int'(spare_code_length_i)) || (b == 0)) begin
                care_d[15 - b] = 1'b1;
            end
        end
        pat_d = {spare_hi_q, spare_code_pattern_low_i} & care_d;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            spare_hi_q <= RLSB_RST_BYTE;
            restart_q  <= 1'b0;
            pat_q      <= 16'h0000;
            care_q     <= 16'h0000;
        end else begin
            spare_hi_q <= spare_hi_d;
            restart_q  <= restart_d;
            pat_q      <= pat_d;
            care_q     <= care_d;
        end
    end

    assign spare_code_pattern_o = pat_q;
    assign spare_code_care_o    = care_q;
    assign spare_code_restart_o = restart_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Read data and interrupt line.

    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;
    logic       int_n_q;
    logic       int_n_d;
    logic [7:0] ls7_view;

    assign ls7_view = e1_mode_i ? e1_q : t1_q;

    // Read data is the value before the clear, so a read never loses what it returns.
    always_comb begin
        rd_data_d = rd_data_q;
        if (host_req_i.rd) begin
            case (host_req_i.addr)
                RLSB_ADDR_LS4:      rd_data_d = ls4_q;
                RLSB_ADDR_HDLC:     rd_data_d = hdlc_q;
                RLSB_ADDR_LS7:      rd_data_d = ls7_view;
                RLSB_ADDR_SIG1:     rd_data_d = sig_q[7:0];
                RLSB_ADDR_SIG2:     rd_data_d = sig_q[15:8];
                RLSB_ADDR_SIG3:     rd_data_d = sig_q[23:16];
                RLSB_ADDR_SIG4:     rd_data_d = e1_mode_i ? sig_q[31:24] : 8'h00;
                RLSB_ADDR_SPARE_HI: rd_data_d = spare_hi_q;
                default:            rd_data_d = 8'h00;
            endcase
        end
        int_n_d = !(|(ls4_q & rx_interrupt_mask_four_i)
                  || |(hdlc_q & hdlc_mask_i)
                  || |(ls7_view & ls7_mask_i));
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            rd_data_q <= RLSB_RST_BYTE;
            int_n_q   <= 1'b1;
        end else begin
            rd_data_q <= rd_data_d;
            int_n_q   <= int_n_d;
        end
    end

    assign rd_data_o     = rd_data_q;
    assign interrupt_n_o = int_n_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    set_wins_a : assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (rd_hdlc && hdlc_pulse_i.packet_end) |=> hdlc_q[RLSB_HD_PE])
        else $error("packet-end event lost during read");

    read_clears_a : assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (rd_hdlc && !hdlc_pulse_i.packet_start) |=> !hdlc_q[RLSB_HD_PS])
        else $error("packet-start flag not cleared by read");

    read_returns_a : assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        rd_sig[1] |=> (rd_data_o == $past(sig_q[15:8])))
        else $error("signaling read returned wrong byte");

    mask_irq_a : assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (hdlc_q[RLSB_HD_OVR] && hdlc_mask_i[RLSB_HD_OVR]) |=> !interrupt_n_o)
        else $error("unmasked overrun did not assert interrupt");

    irq_quiet_a : assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (ls4_q == 8'h00 && hdlc_q == 8'h00 && ls7_view == 8'h00) |=> interrupt_n_o)
        else $error("interrupt without any latched flag");

    wm_edge_a : assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        ($rose(above_watermark_condition) && !rd_hdlc) |=> hdlc_q[RLSB_HD_HWM])
        else $error("watermark crossing not latched");

    t1_high_ch_a : assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (!e1_mode_i && sig_q[31:24] == 8'h00) |=> (sig_q[31:24] == 8'h00))
        else $error("T1 mode latched channels above 24");

    restart_a : assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        wr_spare |=> (spare_code_restart_o && spare_hi_q == $past(host_req_i.wdata)))
        else $error("spare-code write did not restart detector");

    low_ignored_a : assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (spare_code_length_i <= 4'h7 && spare_code_length_i == $past(spare_code_length_i))
        |-> (spare_code_pattern_o[7:0] == 8'h00))
        else $error("low spare-code byte used for short pattern");

    rai_gate_a : assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (!esf_mode_i && !e1_mode_i && rd_ls7) |=> !t1_q[RLSB_T1_RAI])
        else $error("RAI-CI flag set outside ESF");

endmodule
`default_nettype wire

/* tb/rlsb_host_model.sv */
// Host processor model that reads, clears and writes the latched-status bank.
`timescale 1ns/10ps
`default_nettype none
module rlsb_host_model
    import rlsb_pkg::*;
(
    input  wire logic       ref_clk_i,
    output var rlsb_host_req_t host_req_o,
    input  wire logic [7:0] rd_data_i
);
    initial host_req_o = '0;

    // A read is a one-cycle pulse; the answer is taken one cycle later.
    // A released address shows its inverse so that no stale value is mistaken for a request.
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk_i);
        host_req_o = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(negedge ref_clk_i);
        host_req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
        d = rd_data_i;
    endtask

    // A write is a one-cycle pulse with no answer.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] w);
        @(negedge ref_clk_i);
        host_req_o = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: w};
        @(negedge ref_clk_i);
        host_req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~w};
    endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the receive latched-status bank.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module tb;
    import rlsb_pkg::*;
    typedef struct packed {
        logic        e1;
        logic [2:0]  g;
        logic [11:0] ev;
        logic [7:0]  addr;
        logic [7:0]  exp;
    } rlsb_row_t;
    logic ref_clk_i = 1'b0;
    logic resetn_i, e1_mode_i, esf_mode_i, cas_enable_i, mf_boundary_i, opening_byte_at_head_i;
    logic remote_alarm_condition_i, ais_condition_i, boc_valid_i, spare_bit6_codeword_i;
    logic spare_bits_valid_i, spare_code_restart_o, interrupt_n_o;
    logic [7:0] rd_data_o, rx_interrupt_mask_four_i, hdlc_mask_i, ls7_mask_i, d;
    logic [7:0] spare_code_pattern_low_i;
    logic [6:0] fifo_level_i, rx_fifo_control_i;
    logic [4:0] spare_bits_i, spare_bit_select_mask_i;
    logic [3:0] spare_code_length_i;
    logic [31:0] signaling_change_i, signaling_change_enable_i;
    logic [15:0] spare_code_pattern_o, spare_code_care_o;
    rlsb_host_req_t host_req_i;
    rlsb_hdlc_pulse_t hdlc_pulse_i;
    rlsb_t1_pulse_t t1_pulse_i;
    rlsb_row_t r;
    int error_cnt = 0;
    int compares = 0;
    // Mode, gate conditions {esf, remote alarm, ais}, event set, register, expected byte.
    rlsb_row_t rows [17] = '{
        '{1'b0, 3'h7, 12'h001, 8'h93, 8'h01},
        '{1'b1, 3'h7, 12'h001, 8'h93, 8'h01},
        '{1'b0, 3'h7, 12'h008, 8'h94, 8'h20},
        '{1'b0, 3'h7, 12'h004, 8'h94, 8'h08},
        '{1'b0, 3'h7, 12'h002, 8'h94, 8'h04},
        '{1'b0, 3'h7, 12'h100, 8'h94, 8'h03},
        '{1'b0, 3'h7, 12'h200, 8'h94, 8'h10},
        '{1'b0, 3'h7, 12'h080, 8'h96, 8'h20},
        '{1'b0, 3'h3, 12'h080, 8'h96, 8'h00},
        '{1'b0, 3'h5, 12'h080, 8'h96, 8'h00},
        '{1'b0, 3'h7, 12'h040, 8'h96, 8'h10},
        '{1'b0, 3'h6, 12'h040, 8'h96, 8'h00},
        '{1'b0, 3'h7, 12'h020, 8'h96, 8'h08},
        '{1'b0, 3'h7, 12'h010, 8'h96, 8'h04},
        '{1'b0, 3'h7, 12'h400, 8'h96, 8'h03},
        '{1'b1, 3'h7, 12'h800, 8'h96, 8'h02},
        '{1'b1, 3'h7, 12'h080, 8'h96, 8'h00}};
    logic [7:0] addrs [9] = '{8'h93, 8'h94, 8'h96, 8'h98, 8'h99, 8'h9a, 8'h9b, 8'h9c, 8'h90};

    rlsb_status_bank #(.MF_E1_PERIOD_CYC(20)) u_rlsb_status_bank (
        .ref_clk_i, .resetn_i, .host_req_i, .rd_data_o, .e1_mode_i, .esf_mode_i,
        .cas_enable_i, .mf_boundary_i, .hdlc_pulse_i, .opening_byte_at_head_i, .fifo_level_i,
        .rx_fifo_control_i, .t1_pulse_i, .remote_alarm_condition_i, .ais_condition_i,
        .boc_valid_i, .spare_bit6_codeword_i, .spare_bits_i, .spare_bits_valid_i,
        .spare_bit_select_mask_i, .signaling_change_i, .signaling_change_enable_i,
        .rx_interrupt_mask_four_i, .hdlc_mask_i, .ls7_mask_i, .spare_code_length_i,
        .spare_code_pattern_low_i, .spare_code_pattern_o, .spare_code_care_o,
        .spare_code_restart_o, .interrupt_n_o);
    rlsb_host_model u_rlsb_host_model (
        .ref_clk_i(ref_clk_i), .host_req_o(host_req_i), .rd_data_i(rd_data_o));

    // 250 MHz clock.
    always #2 ref_clk_i = ~ref_clk_i;

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    // Read and compare in one go.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        u_rlsb_host_model.rd_reg(a, d);
        `CHK("rd_data_o", e, d)
    endtask

    // Drop every event input back to its quiet value.
    task automatic idle();
        {spare_bit6_codeword_i, boc_valid_i, opening_byte_at_head_i, mf_boundary_i} = '0;
        {spare_bits_valid_i, fifo_level_i, t1_pulse_i, hdlc_pulse_i} = '0;
        signaling_change_i = 32'h0000_0000;
    endtask

    // One Sa sample, held a single cycle.
    task automatic sa(input logic [4:0] b);
        spare_bits_i = b;
        spare_bits_valid_i = 1'b1;
        cyc(1);
        spare_bits_valid_i = 1'b0;
        cyc(2);
    endtask

    task automatic end_of_test();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // A hang is cut short here and counted as a mismatch.
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        error_cnt++;
        end_of_test();
    end

    initial begin
        idle();
        {resetn_i, e1_mode_i, esf_mode_i, cas_enable_i} = 4'b0011;
        {remote_alarm_condition_i, ais_condition_i, spare_bits_i} = '0;
        {rx_interrupt_mask_four_i, hdlc_mask_i, ls7_mask_i} = '1;
        {rx_fifo_control_i, spare_bit_select_mask_i} = {7'd5, 5'h1f};
        {spare_code_length_i, spare_code_pattern_low_i} = {4'd1, 8'h00};
        signaling_change_enable_i = 32'h0000_0001;
        cyc(8);
        resetn_i = 1'b1;
        `CHK("interrupt_n_o", 1'b1, interrupt_n_o)
        `CHK("spare_code_care_o", 16'h0000, spare_code_care_o)
        foreach (addrs[i]) rd(addrs[i], 8'h00);
        $display("test reset done");
        // Table of single events, each read twice to see clear-on-read.
        foreach (rows[i]) begin
            r = rows[i];
            {esf_mode_i, remote_alarm_condition_i, ais_condition_i} = r.g;
            e1_mode_i = r.e1;
            cyc(2);
            {spare_bit6_codeword_i, boc_valid_i, opening_byte_at_head_i} = r.ev[11:9];
            fifo_level_i = r.ev[8] ? 7'd10 : 7'd0;
            {t1_pulse_i, hdlc_pulse_i, mf_boundary_i} = r.ev[7:0];
            cyc(1);
            idle();
            cyc(2);
            `CHK("interrupt_n_o", r.exp == 8'h00, interrupt_n_o)
            rd(r.addr, r.exp);
            rd(r.addr, 8'h00);
            `CHK("interrupt_n_o", 1'b1, interrupt_n_o)
        end
        $display("test event table done");
        // Event landing on the very edge that reads its register.
        fork
            rd(RLSB_ADDR_HDLC, 8'h00);
            begin cyc(1); hdlc_pulse_i.packet_end = 1'b1; cyc(1); idle(); end
        join
        rd(RLSB_ADDR_HDLC, 8'h08);
        // A cleared mask bit keeps the flag off the interrupt line.
        hdlc_mask_i = 8'h00;
        hdlc_pulse_i.overrun = 1'b1;
        cyc(1);
        idle();
        cyc(3);
        `CHK("interrupt_n_o", 1'b1, interrupt_n_o)
        hdlc_mask_i = 8'hff;
        cyc(2);
        `CHK("interrupt_n_o", 1'b0, interrupt_n_o)
        rd(RLSB_ADDR_HDLC, 8'h20);
        $display("test mask done");
        // Signaling changes: T1 ignores the top byte, only enabled channels reach the summary.
        e1_mode_i = 1'b0;
        signaling_change_i = 32'h8000_0101;
        cyc(1);
        idle();
        cyc(2);
        rd(RLSB_ADDR_SIG1, 8'h01);
        rd(RLSB_ADDR_SIG2, 8'h01);
        rd(RLSB_ADDR_SIG4, 8'h00);
        rd(RLSB_ADDR_LS4, 8'h08);
        signaling_change_i = 32'h0000_0100;
        cyc(1);
        idle();
        cyc(2);
        rd(RLSB_ADDR_LS4, 8'h00);
        e1_mode_i = 1'b1;
        signaling_change_i = 32'h8001_0000;
        cyc(1);
        idle();
        cyc(2);
        rd(RLSB_ADDR_SIG3, 8'h01);
        rd(RLSB_ADDR_SIG4, 8'h80);
        $display("test signaling done");
        // Free-running E1 multiframe period with signaling off.
        cas_enable_i = 1'b0;
        cyc(25);
        cas_enable_i = 1'b1;
        rd(RLSB_ADDR_LS4, 8'h01);
        // Sa change detection honours the select mask.
        sa(5'h00);
        u_rlsb_host_model.rd_reg(RLSB_ADDR_LS7, d);
        sa(5'h01);
        rd(RLSB_ADDR_LS7, 8'h01);
        spare_bit_select_mask_i = 5'h1e;
        sa(5'h00);
        rd(RLSB_ADDR_LS7, 8'h00);
        $display("test e1 done");
        // Spare code: restart pulse, MSB-first care bits, low byte ignored up to seven bits.
        e1_mode_i = 1'b0;
        spare_code_length_i = 4'd3;
        u_rlsb_host_model.wr_reg(RLSB_ADDR_SPARE_HI, 8'ha5);
        `CHK("spare_code_restart_o", 1'b1, spare_code_restart_o)
        cyc(1);
        `CHK("spare_code_restart_o", 1'b0, spare_code_restart_o)
        `CHK("spare_code_pattern_o", 16'ha000, spare_code_pattern_o)
        rd(RLSB_ADDR_SPARE_HI, 8'ha5);
        spare_code_length_i = 4'd7;
        spare_code_pattern_low_i = 8'h5a;
        cyc(2);
        `CHK("spare_code_care_o", 16'hfe00, spare_code_care_o)
        `CHK("spare_code_pattern_o", 16'ha400, spare_code_pattern_o)
        spare_code_length_i = 4'd12;
        cyc(2);
        `CHK("spare_code_pattern_o", 16'ha550, spare_code_pattern_o)
        $display("test spare code done");
        // A reset in mid-run drops a pending flag, the interrupt and the spare-code byte.
        hdlc_pulse_i.overrun = 1'b1;
        cyc(1);
        idle();
        resetn_i = 1'b0;
        cyc(2);
        resetn_i = 1'b1;
        `CHK("interrupt_n_o", 1'b1, interrupt_n_o)
        rd(RLSB_ADDR_HDLC, 8'h00);
        rd(RLSB_ADDR_SPARE_HI, 8'h00);
        $display("test reset in run done");
        end_of_test();
    end
endmodule
`default_nettype wire
